//--- pkg/clkout_pkg.sv
// constants, carriers and state codes for the clock output and drive control block
package clkout_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_CLKOUT_CTRL = 8'h1c;
    localparam logic [7:0] ADDR_DRIVE_SEL = 8'h20;
    localparam logic [7:0] ADDR_RESERVED = 8'h24;

    // clock_output_control fields
    localparam int PRIMARY_DIS_BIT = 7;
    localparam int DOUBLE_DIS_BIT = 6;
    localparam int PREDIV_BIT = 5;
    localparam int DIV_LSB = 0;
    localparam int DIV_W = 5;
    localparam int PREDIV_RATIO = 16;

    // port_drive_strength_select fields
    localparam int LOW_DRIVE_K_BIT = 7;
    localparam int LOW_DRIVE_E_BIT = 4;
    localparam int LOW_DRIVE_B_BIT = 1;
    localparam int LOW_DRIVE_A_BIT = 0;
    localparam logic [7:0] DRIVE_SEL_MASK = 8'h93;

    // shared port E pin carrying the primary clock
    localparam int CLKOUT_PIN_E = 4;

    // reset values
    localparam logic [7:0] CTRL_RESET_SPECIAL = 8'h40;
    localparam logic [7:0] CTRL_RESET_NORMAL = 8'hc0;
    localparam logic [7:0] DRIVE_SEL_RESET = 8'h00;
    localparam logic [7:0] RESERVED_VALUE = 8'h00;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axil_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_s;

    typedef struct packed {
        logic [7:0] k;
        logic [7:0] e;
        logic [7:0] b;
        logic [7:0] a;
    } port_bits_s;

    typedef enum logic [1:0] {
        WR_COLLECT = 2'h1,
        WR_RESP = 2'h2
    } wr_state_e;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h1,
        RD_RESP = 2'h2
    } rd_state_e;

endpackage : clkout_pkg

//--- rtl/clock_out_and_drive_ctrl.sv
// clock outputs, reduced-drive selects and their AXI4-Lite register file
//
// Summary of operation
// RULE1: primary disable bit 0 drives a free-running bus-derived clock; 1 suppresses it.
// RULE2: double-rate disable bit 0 drives the twice-bus clock; 1 disables it.
// RULE3: predivide bit set divides the divided clock further by sixteen.
// RULE4: primary clock is bus clock divided by divider field plus one.
// RULE5: clock control register is readable and writable any time, any mode.
// RULE6: one low-drive bit per port: K bit 7, E 4, B 1, A 0.
// RULE7: a low-drive bit has no effect on pins configured as inputs.
// RULE8: low drive applies to output pins whatever function drives them.
// RULE9: the reserved register reads zero and ignores writes.
// RULE10: an enabled primary clock takes the shared port E pin from GPIO.
// RULE11: divider settings change only at a divided-clock period boundary.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

module clock_out_and_drive_ctrl #(
    parameter int DIV_W = clkout_pkg::DIV_W,
    parameter int PREDIV_RATIO = clkout_pkg::PREDIV_RATIO
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clk_x2,
    // operating mode, caught after reset release
    input wire logic special_mode,
    // register bus
    input wire clkout_pkg::axil_req_s axil_req,
    output clkout_pkg::axil_rsp_s axil_rsp,
    // port direction bits, 1 = output
    input wire clkout_pkg::port_bits_s port_dir,
    // shared port E pin
    input wire logic gpio_pe_clk_pin_out,
    output logic pe_clk_pin_out,
    output logic pe_clk_pin_oe_n,
    // clock outputs
    output logic primary_clock_output,
    output logic double_rate_clock_output,
    // per-pin reduced drive
    output clkout_pkg::port_bits_s pin_low_drive
);

    if (DIV_W != clkout_pkg::DIV_W || PREDIV_RATIO != clkout_pkg::PREDIV_RATIO) begin : g_chk
        $error("divider width and predivide ratio are fixed by the register layout");
    end

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] drive_sel;
        logic mode_pending;
        clkout_pkg::wr_state_e wr_st;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic [1:0] bresp;
        clkout_pkg::rd_state_e rd_st;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic act_en;
        logic act_pre;
        logic [DIV_W-1:0] act_div;
        logic [DIV_W-1:0] div_cnt;
        logic [3:0] pre_cnt;
        logic pri_level;
        logic dbl_en;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic addr_known(input logic [7:0] addr);
        addr_known = (addr == clkout_pkg::ADDR_CLKOUT_CTRL) ||
                     (addr == clkout_pkg::ADDR_DRIVE_SEL) ||
                     (addr == clkout_pkg::ADDR_RESERVED);
    endfunction : addr_known

    function automatic logic [7:0] reg_value(input logic [7:0] addr, input state_s s);
        reg_value = 8'h00;
        if (addr == clkout_pkg::ADDR_CLKOUT_CTRL) begin
            reg_value = s.ctrl;
        end else if (addr == clkout_pkg::ADDR_DRIVE_SEL) begin
            reg_value = s.drive_sel;
        end else if (addr == clkout_pkg::ADDR_RESERVED) begin
            // RULE9: reserved reads zero
            reg_value = clkout_pkg::RESERVED_VALUE;
        end
    endfunction : reg_value

    ////////////////////////////////////////////////////////////////////////
    // next state

    logic do_write;
    logic boundary;
    logic [DIV_W-1:0] div_next;
    logic [3:0] pre_next;

    always_comb begin
        nxt_st = st_ff;
        do_write = 1'b0;
        div_next = '0;
        pre_next = 4'h0;

        // mode-dependent reset value of the primary disable bit
        if (st_ff.mode_pending) begin
            nxt_st.mode_pending = 1'b0;
            nxt_st.ctrl = special_mode ? clkout_pkg::CTRL_RESET_SPECIAL
                                       : clkout_pkg::CTRL_RESET_NORMAL;
        end

        // write channel: address and data taken in either order
        unique case (st_ff.wr_st)
            clkout_pkg::WR_COLLECT: begin
                if (axil_req.awvalid && !st_ff.aw_got) begin
                    nxt_st.aw_got = 1'b1;
                    nxt_st.aw_addr = axil_req.awaddr;
                end
                if (axil_req.wvalid && !st_ff.w_got) begin
                    nxt_st.w_got = 1'b1;
                    nxt_st.w_data = axil_req.wdata;
                    nxt_st.w_strb = axil_req.wstrb;
                end
                if (st_ff.aw_got && st_ff.w_got) begin
                    do_write = 1'b1;
                    nxt_st.aw_got = 1'b0;
                    nxt_st.w_got = 1'b0;
                    nxt_st.bresp = addr_known(st_ff.aw_addr) ? clkout_pkg::RESP_OKAY
                                                             : clkout_pkg::RESP_SLVERR;
                    nxt_st.wr_st = clkout_pkg::WR_RESP;
                end
            end
            clkout_pkg::WR_RESP: begin
                if (axil_req.bready) begin
                    nxt_st.wr_st = clkout_pkg::WR_COLLECT;
                end
            end
            default: begin
                nxt_st.wr_st = clkout_pkg::WR_COLLECT;
            end
        endcase

        // RULE5: control register written at any time, in every mode
        if (do_write && st_ff.w_strb[0]) begin
            if (st_ff.aw_addr == clkout_pkg::ADDR_CLKOUT_CTRL) begin
                nxt_st.ctrl = st_ff.w_data[7:0];
                nxt_st.mode_pending = 1'b0;
            end else if (st_ff.aw_addr == clkout_pkg::ADDR_DRIVE_SEL) begin
                // RULE6: only the four port bits are held
                nxt_st.drive_sel = st_ff.w_data[7:0] & clkout_pkg::DRIVE_SEL_MASK;
            end
            // RULE9: writes to the reserved register are dropped
        end

        // read channel
        unique case (st_ff.rd_st)
            clkout_pkg::RD_IDLE: begin
                if (axil_req.arvalid) begin
                    nxt_st.rdata = {24'h000000, reg_value(axil_req.araddr, st_ff)};
                    nxt_st.rresp = addr_known(axil_req.araddr) ? clkout_pkg::RESP_OKAY
                                                               : clkout_pkg::RESP_SLVERR;
                    nxt_st.rd_st = clkout_pkg::RD_RESP;
                end
            end
            clkout_pkg::RD_RESP: begin
                if (axil_req.rready) begin
                    nxt_st.rd_st = clkout_pkg::RD_IDLE;
                end
            end
            default: begin
                nxt_st.rd_st = clkout_pkg::RD_IDLE;
            end
        endcase

        // RULE11: end of a whole output period, or output idle
        boundary = !st_ff.act_en ||
                   ((st_ff.div_cnt == st_ff.act_div) &&
                    (!st_ff.act_pre || st_ff.pre_cnt == 4'(PREDIV_RATIO - 1)));

        if (boundary) begin
            // RULE11: new settings taken only here
            nxt_st.act_en = !st_ff.ctrl[clkout_pkg::PRIMARY_DIS_BIT];
            nxt_st.act_pre = st_ff.ctrl[clkout_pkg::PREDIV_BIT];
            nxt_st.act_div = st_ff.ctrl[clkout_pkg::DIV_LSB +: DIV_W];
        end else if (st_ff.div_cnt == st_ff.act_div) begin
            // RULE4: divided period is act_div plus one bus cycles
            pre_next = st_ff.pre_cnt + 4'h1;
        end else begin
            div_next = st_ff.div_cnt + 1'b1;
            pre_next = st_ff.pre_cnt;
        end
        nxt_st.div_cnt = div_next;
        nxt_st.pre_cnt = pre_next;

        // RULE3: with the predivider, high for the first half of sixteen divided periods
        if (nxt_st.act_pre) begin
            nxt_st.pri_level = nxt_st.act_en && (pre_next < 4'(PREDIV_RATIO / 2));
        end else begin
            nxt_st.pri_level = nxt_st.act_en && (div_next <= (nxt_st.act_div >> 1));
        end

        // RULE2: double-rate enable follows its disable bit
        nxt_st.dbl_en = !nxt_st.ctrl[clkout_pkg::DOUBLE_DIS_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st_ff <= '0;
            st_ff.ctrl <= clkout_pkg::CTRL_RESET_NORMAL;
            st_ff.drive_sel <= clkout_pkg::DRIVE_SEL_RESET;
            st_ff.mode_pending <= 1'b1;
            st_ff.wr_st <= clkout_pkg::WR_COLLECT;
            st_ff.rd_st <= clkout_pkg::RD_IDLE;
            st_ff.bresp <= clkout_pkg::RESP_OKAY;
            st_ff.rresp <= clkout_pkg::RESP_OKAY;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus answers

    always_comb begin
        axil_rsp.awready = (st_ff.wr_st == clkout_pkg::WR_COLLECT) && !st_ff.aw_got;
        axil_rsp.wready = (st_ff.wr_st == clkout_pkg::WR_COLLECT) && !st_ff.w_got;
        axil_rsp.bvalid = (st_ff.wr_st == clkout_pkg::WR_RESP);
        axil_rsp.bresp = st_ff.bresp;
        axil_rsp.arready = (st_ff.rd_st == clkout_pkg::RD_IDLE);
        axil_rsp.rvalid = (st_ff.rd_st == clkout_pkg::RD_RESP);
        axil_rsp.rdata = st_ff.rdata;
        axil_rsp.rresp = st_ff.rresp;
    end

    ////////////////////////////////////////////////////////////////////////
    // clock outputs and pins

    localparam int CLKOUT_PIN_E_IDX = clkout_pkg::CLKOUT_PIN_E;

    logic bypass;
    logic drive_e_clk;

    // RULE4: field zero without predivider passes the bus clock itself
    assign bypass = (st_ff.act_div == '0) && !st_ff.act_pre;

    // RULE1: gated clock, held low while disabled
    assign primary_clock_output = st_ff.act_en && (bypass ? clk_sys : st_ff.pri_level);

    // RULE2: twice-rate clock gated by its enable
    assign double_rate_clock_output = clk_x2 && st_ff.dbl_en;

    // RULE10: clock output wins the shared pin over GPIO
    assign drive_e_clk = st_ff.act_en;
    assign pe_clk_pin_out = drive_e_clk ? primary_clock_output : gpio_pe_clk_pin_out;
    assign pe_clk_pin_oe_n = !(drive_e_clk || port_dir.e[CLKOUT_PIN_E_IDX]);

    // RULE7: only pins acting as outputs take low drive
    // RULE8: whichever function drives the pin
    always_comb begin
        pin_low_drive.k = port_dir.k & {8{st_ff.drive_sel[clkout_pkg::LOW_DRIVE_K_BIT]}};
        pin_low_drive.b = port_dir.b & {8{st_ff.drive_sel[clkout_pkg::LOW_DRIVE_B_BIT]}};
        pin_low_drive.a = port_dir.a & {8{st_ff.drive_sel[clkout_pkg::LOW_DRIVE_A_BIT]}};
        pin_low_drive.e = port_dir.e & {8{st_ff.drive_sel[clkout_pkg::LOW_DRIVE_E_BIT]}};
        pin_low_drive.e[CLKOUT_PIN_E_IDX] = !pe_clk_pin_oe_n &&
                                           st_ff.drive_sel[clkout_pkg::LOW_DRIVE_E_BIT];
    end

endmodule : clock_out_and_drive_ctrl

//--- testbench/clkout_chk.sv
// port checker for the clock output and drive control block
`timescale 1ns/100ps
module clkout_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // register bus
    input wire clkout_pkg::axil_req_s axil_req,
    input wire clkout_pkg::axil_rsp_s axil_rsp,
    // pins
    input wire clkout_pkg::port_bits_s port_dir,
    input wire logic pe_clk_pin_out,
    input wire logic pe_clk_pin_oe_n,
    input wire logic primary_clock_output,
    input wire clkout_pkg::port_bits_s pin_low_drive
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence wr_both_taken;
        axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
    endsequence
    sequence rd_taken;
        axil_req.arvalid && axil_rsp.arready;
    endsequence
    wr_resp_time_a: assert property (wr_both_taken |=> !axil_rsp.bvalid ##1 axil_rsp.bvalid)
        else $error("write answer late or early");
    rd_resp_time_a: assert property (rd_taken |=> axil_rsp.rvalid)
        else $error("read answer missing");
    rd_hold_a: assert property (axil_rsp.rvalid && !axil_req.rready
        |=> axil_rsp.rvalid && $stable(axil_rsp.rdata)) else $error("read data dropped");
    wr_hold_a: assert property (axil_rsp.bvalid && !axil_req.bready
        |=> axil_rsp.bvalid && $stable(axil_rsp.bresp)) else $error("write answer dropped");
    rd_refuse_a: assert property (axil_rsp.rvalid |-> !axil_rsp.arready)
        else $error("read accepted while answer pending");
    rsv_read_a: assert property (rd_taken ##0 axil_req.araddr == clkout_pkg::ADDR_RESERVED
        |=> axil_rsp.rdata == 32'h0 && axil_rsp.rresp == clkout_pkg::RESP_OKAY)
        else $error("reserved read not zero");
    input_pin_a: assert property (((pin_low_drive & ~port_dir) & 32'hffef_ffff) == 32'h0)
        else $error("low drive on input pin");
    shared_drive_a: assert property (pin_low_drive.e[4] |-> !pe_clk_pin_oe_n)
        else $error("low drive on released pin");
    shared_enable_a: assert property (pe_clk_pin_oe_n |-> !port_dir.e[4])
        else $error("output pin released");
    clock_priority_a: assert property (!pe_clk_pin_oe_n && !port_dir.e[4]
        |-> pe_clk_pin_out == primary_clock_output) else $error("pin not carrying clock");
endmodule : clkout_chk
bind clock_out_and_drive_ctrl clkout_chk clkout_chk_i (.clk_sys(clk_sys), .resetn(resetn),
    .axil_req(axil_req), .axil_rsp(axil_rsp), .port_dir(port_dir),
    .pe_clk_pin_out(pe_clk_pin_out), .pe_clk_pin_oe_n(pe_clk_pin_oe_n),
    .primary_clock_output(primary_clock_output), .pin_low_drive(pin_low_drive));

//--- testbench/pin_observer.sv
// external circuit that measures the clock pins
`timescale 1ns/100ps
module pin_observer (
    // observed pins
    input wire logic primary_clock_output,
    input wire logic double_rate_clock_output,
    // measurements
    output logic [31:0] period_ns,
    output logic [31:0] edge_cnt,
    output logic [31:0] dbl_cnt
);
    realtime last_t = 0.0;
    initial period_ns = 32'h0;
    initial edge_cnt = 32'h0;
    initial dbl_cnt = 32'h0;
    // time between the last two rising edges
    always @(posedge primary_clock_output) begin
        period_ns <= 32'($rtoi($realtime - last_t));
        last_t = $realtime;
        edge_cnt <= edge_cnt + 32'h1;
    end
    always @(posedge double_rate_clock_output) begin
        dbl_cnt <= dbl_cnt + 32'h1;
    end
endmodule : pin_observer

//--- testbench/clock_out_and_drive_ctrl_tb_top.sv
// self-checking bench for the clock output and drive control block
`timescale 1ns/100ps
module clock_out_and_drive_ctrl_tb_top;
    logic clk_sys = 1'b0;
    logic clk_x2 = 1'b0;
    logic resetn = 1'b0;
    logic special_mode = 1'b0;
    logic gpio_pin = 1'b0;
    clkout_pkg::axil_req_s req = '0;
    clkout_pkg::axil_rsp_s rsp;
    clkout_pkg::port_bits_s port_dir = '0;
    clkout_pkg::port_bits_s low_drv;
    logic pin_out, pin_oe_n, prim_clk, dbl_clk;
    logic [31:0] period_ns, edge_cnt, dbl_cnt, per, e0;
    logic [33:0] exp_q[$];
    logic [7:0] v;
    logic [7:0] cfg[6] = '{8'h00, 8'h01, 8'h02, 8'h1f, 8'h23, 8'h20};
    int err_total = 0;
    int check_count = 0;
    always #50 clk_sys = ~clk_sys;
    always #25 clk_x2 = ~clk_x2;
    clock_out_and_drive_ctrl clock_out_and_drive_ctrl_i (.clk_sys(clk_sys), .resetn(resetn),
        .clk_x2(clk_x2), .special_mode(special_mode), .axil_req(req), .axil_rsp(rsp),
        .port_dir(port_dir), .gpio_pe_clk_pin_out(gpio_pin), .pe_clk_pin_out(pin_out),
        .pe_clk_pin_oe_n(pin_oe_n), .primary_clock_output(prim_clk),
        .double_rate_clock_output(dbl_clk), .pin_low_drive(low_drv));
    pin_observer pin_observer_i (.primary_clock_output(prim_clk),
        .double_rate_clock_output(dbl_clk), .period_ns(period_ns), .edge_cnt(edge_cnt),
        .dbl_cnt(dbl_cnt));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        exp_q.push_back({r, 32'h0});
        @(posedge clk_sys);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= {24'h0, d};
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        req.bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        logic rd_done;
        exp_q.push_back({r, 24'h0, d});
        @(posedge clk_sys);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        // a late rready makes the slave hold its answer for a cycle
        req.rready <= 1'($urandom);
        do @(posedge clk_sys); while (!rsp.arready);
        req.arvalid <= 1'b0;
        do begin
            @(posedge clk_sys);
            rd_done = rsp.rvalid && req.rready;
            req.rready <= !rd_done;
        end while (!rd_done);
    endtask : rd
    // answers are matched against the oldest note
    always @(posedge clk_sys) begin
        if (rsp.rvalid && req.rready) check({rsp.rresp, rsp.rdata}, exp_q.pop_front());
        if (rsp.bvalid && req.bready) check({rsp.bresp, 32'h0}, exp_q.pop_front());
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(93));
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(clkout_pkg::ADDR_CLKOUT_CTRL, 8'hc0, clkout_pkg::RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom);
            port_dir <= $urandom;
            gpio_pin <= 1'($urandom);
            wr(clkout_pkg::ADDR_CLKOUT_CTRL, v, clkout_pkg::RESP_OKAY);
            rd(clkout_pkg::ADDR_CLKOUT_CTRL, v, clkout_pkg::RESP_OKAY);
            wr(clkout_pkg::ADDR_DRIVE_SEL, v, clkout_pkg::RESP_OKAY);
            rd(clkout_pkg::ADDR_DRIVE_SEL, v & clkout_pkg::DRIVE_SEL_MASK, 2'h0);
            // enable takes effect at the end of the running period, at most 512 cycles
            repeat (520) @(posedge clk_sys);
            check(34'(pin_oe_n), 34'(!(!v[7] || port_dir.e[4])));
            check(34'(low_drv.a), 34'(port_dir.a & {8{v[0]}}));
            check(34'(low_drv.b), 34'(port_dir.b & {8{v[1]}}));
            check(34'(low_drv.k), 34'(port_dir.k & {8{v[7]}}));
            check(34'(low_drv.e), 34'((port_dir.e | {3'h0, ~v[7], 4'h0}) & {8{v[4]}}));
            if (v[7] && port_dir.e[4]) check(34'(pin_out), 34'(gpio_pin));
        end
        wr(clkout_pkg::ADDR_RESERVED, 8'hff, clkout_pkg::RESP_OKAY);
        rd(clkout_pkg::ADDR_RESERVED, 8'h00, clkout_pkg::RESP_OKAY);
        wr(8'h30, 8'h55, clkout_pkg::RESP_SLVERR);
        rd(8'h30, 8'h00, clkout_pkg::RESP_SLVERR);
        foreach (cfg[j]) begin
            wr(clkout_pkg::ADDR_CLKOUT_CTRL, cfg[j], clkout_pkg::RESP_OKAY);
            per = (32'(cfg[j][4:0]) + 32'h1) * (cfg[j][5] ? 32'd1600 : 32'd100);
            repeat (per / 25 + 560) @(posedge clk_sys);
            check(34'(period_ns), 34'(per));
        end
        for (int j = 0; j < 2; j++) begin
            wr(clkout_pkg::ADDR_CLKOUT_CTRL, j ? 8'h00 : 8'hc0, clkout_pkg::RESP_OKAY);
            repeat (40) @(posedge clk_sys);
            e0 = edge_cnt;
            per = dbl_cnt;
            repeat (10) @(posedge clk_sys);
            check(34'(edge_cnt - e0), j ? 34'd10 : 34'd0);
            check(34'(dbl_cnt - per), j ? 34'd20 : 34'd0);
        end
        resetn <= 1'b0;
        special_mode <= 1'b1;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(clkout_pkg::ADDR_CLKOUT_CTRL, 8'h40, clkout_pkg::RESP_OKAY);
        complete_run();
    end
    initial begin
        #2_000_000;
        err_total++;
        complete_run();
    end
endmodule : clock_out_and_drive_ctrl_tb_top
